// *** sbt_timer.sv ***
// Sixteen-bit capture and compare timer with an APB register slave
// ==========================================================
`timescale 1ns/100ps
`default_nettype none
module sbt_timer #(
	parameter logic [2:0] INPUT_BONDED = 3'b111
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        capture_input_one,
	input  wire logic        capture_input_two,
	input  wire logic        external_tick_input,
	output logic             compare_output_one,
	output logic             compare_output_one_oe,
	output logic             compare_output_two,
	output logic             compare_output_two_oe,
	output logic             irq_compare,
	output logic             irq_capture,
	output logic             irq_overflow
);

	sbt_pkg::sbt_ctrl_type ctrl;
	logic                  timer_freeze;
	logic [15:0]           count;
	logic [15:0]           next_count;
	logic [15:0]           compare_one_value;
	logic [15:0]           compare_two_value;
	logic [15:0]           capture_one_value;
	logic [15:0]           capture_two_value;
	logic [4:0]            flags;
	logic [4:0]            armed;
	logic [4:0]            flag_set;
	logic [4:0]            low_acc;
	logic [4:0]            flag_clr;
	logic [2:0]            pin_meta;
	logic [2:0]            pin_sync;
	logic [2:0]            pin_seen;
	logic [2:0]            pin_prev;
	logic                  tick;
	logic                  raw_tick;
	logic                  setup;
	logic                  done;
	logic                  wr_done;
	logic                  mapped;
	logic [7:0]            rd_byte;
	logic                  cap1_evt;
	logic                  cap2_evt;
	logic                  cmp1_hit;
	logic                  cmp2_hit;
	logic                  ovf_evt;
	logic                  restart;
	logic                  cnt_low_wr;
	logic                  status_rd;
	logic                  lvl1;
	logic                  lvl2;

	function automatic logic sbt_hit(input logic d, input logic [7:0] a, input logic [7:0] b);
		return d && (a == b);
	endfunction : sbt_hit

	// ==========================================================
	// Pin synchronisers; only the second stage is read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 3'h7;
			pin_sync <= 3'h7;
			pin_prev <= 3'h7;
		end else begin
			pin_meta <= {external_tick_input, capture_input_two, capture_input_one};
			pin_sync <= pin_meta;
			pin_prev <= pin_seen;
		end
	end

	assign pin_seen = pin_sync | ~INPUT_BONDED;
	assign cap1_evt = sbt_pkg::sbt_edge(pin_seen[0], pin_prev[0], ctrl.cap1_rise);
	assign cap2_evt = sbt_pkg::sbt_edge(pin_seen[1], pin_prev[1], ctrl.cap2_rise);

	// ==========================================================
	// Prescaler
	sbt_prescaler u_prescaler (
		.pclk      (pclk),
		.presetn   (presetn),
		.freeze    (timer_freeze),
		.clk_sel   (ctrl.clk_sel),
		.ext_rise  (ctrl.ext_rise),
		.ext_level (pin_seen[2]),
		.tick      (raw_tick)
	);

	// A tick launched just before freeze was set must not move the counter
	assign tick = raw_tick & ~timer_freeze;

	// ==========================================================
	// APB handshake: data is prepared in setup, so access ends in one cycle
	assign setup   = psel & ~penable;
	assign done    = psel & penable & pready;
	assign wr_done = done & pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// Read mux; reserved status bits read as zero
	always_comb begin
		mapped  = 1'b1;
		rd_byte = 8'h00;
		case (paddr)
			sbt_pkg::ADDR_CTRL:      rd_byte = ctrl[7:0];
			sbt_pkg::ADDR_STATUS:    rd_byte = {flags, timer_freeze, 2'b00};
			sbt_pkg::ADDR_CAP1_HIGH: rd_byte = capture_one_value[15:8];
			sbt_pkg::ADDR_CAP1_LOW:  rd_byte = capture_one_value[7:0];
			sbt_pkg::ADDR_CMP1_HIGH: rd_byte = compare_one_value[15:8];
			sbt_pkg::ADDR_CMP1_LOW:  rd_byte = compare_one_value[7:0];
			sbt_pkg::ADDR_CNT_HIGH,
			sbt_pkg::ADDR_ALT_HIGH:  rd_byte = count[15:8];
			sbt_pkg::ADDR_CNT_LOW,
			sbt_pkg::ADDR_ALT_LOW:   rd_byte = count[7:0];
			sbt_pkg::ADDR_CAP2_HIGH: rd_byte = capture_two_value[15:8];
			sbt_pkg::ADDR_CAP2_LOW:  rd_byte = capture_two_value[7:0];
			sbt_pkg::ADDR_CMP2_HIGH: rd_byte = compare_two_value[15:8];
			sbt_pkg::ADDR_CMP2_LOW:  rd_byte = compare_two_value[7:0];
			default:                 mapped  = 1'b0;
		endcase
		if (paddr == sbt_pkg::ADDR_CTRL) begin
			rd_byte = ctrl[7:0];
		end
	end

	// ==========================================================
	// Control and compare registers; writable whether frozen or not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl              <= sbt_pkg::CTRL_RESET;
			timer_freeze      <= 1'b0;
			compare_one_value <= sbt_pkg::CMP_RESET;
			compare_two_value <= sbt_pkg::CMP_RESET;
		end else if (wr_done) begin
			case (paddr)
				sbt_pkg::ADDR_CTRL:      ctrl <= sbt_pkg::sbt_ctrl_type'(pwdata[13:0]);
				sbt_pkg::ADDR_STATUS:    timer_freeze <= pwdata[sbt_pkg::BIT_FREEZE];
				sbt_pkg::ADDR_CMP1_HIGH: compare_one_value[15:8] <= pwdata[7:0];
				sbt_pkg::ADDR_CMP1_LOW:  compare_one_value[7:0]  <= pwdata[7:0];
				sbt_pkg::ADDR_CMP2_HIGH: compare_two_value[15:8] <= pwdata[7:0];
				sbt_pkg::ADDR_CMP2_LOW:  compare_two_value[7:0]  <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Counter; a write to its low byte restarts it even while frozen
	assign next_count = count + 16'h0001;
	assign cnt_low_wr = sbt_hit(wr_done, paddr, sbt_pkg::ADDR_CNT_LOW);
	assign cmp1_hit   = tick & (next_count == compare_one_value);
	assign cmp2_hit   = tick & (next_count == compare_two_value);
	assign restart    = (ctrl.pwm & cmp2_hit) | (ctrl.opm & cap1_evt & ~timer_freeze);
	assign ovf_evt    = tick & (count == sbt_pkg::CNT_MAX) & ~restart & ~cnt_low_wr;

	// Fixed reset value keeps separate instances counting in step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= sbt_pkg::CNT_RESET;
		end else if (cnt_low_wr || restart) begin
			count <= sbt_pkg::CNT_RESET;
		end else if (tick) begin
			count <= next_count;
		end
	end

	// Capture registers take the live count, high byte in the high half
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_one_value <= sbt_pkg::CAP_RESET;
			capture_two_value <= sbt_pkg::CAP_RESET;
		end else begin
			if (cap1_evt) begin
				capture_one_value <= count;
			end
			if (cap2_evt) begin
				capture_two_value <= count;
			end
		end
	end

	// ==========================================================
	// Flags: set beats clear; clear needs an earlier status read
	assign flag_set  = {cap1_evt, cmp1_hit, ovf_evt, cap2_evt, cmp2_hit};
	assign status_rd = done & ~pwrite & (paddr == sbt_pkg::ADDR_STATUS);
	assign low_acc   = {sbt_hit(done, paddr, sbt_pkg::ADDR_CAP1_LOW),
	                    sbt_hit(done, paddr, sbt_pkg::ADDR_CMP1_LOW),
	                    sbt_hit(done, paddr, sbt_pkg::ADDR_CNT_LOW),
	                    sbt_hit(done, paddr, sbt_pkg::ADDR_CAP2_LOW),
	                    sbt_hit(done, paddr, sbt_pkg::ADDR_CMP2_LOW)};
	assign flag_clr  = low_acc & armed;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= 5'h00;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
		end
	end

	// Arm only the flags that the status read actually returned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed <= 5'h00;
		end else if (status_rd) begin
			armed <= prdata[7:sbt_pkg::FLAG_LSB];
		end else begin
			armed <= armed & ~low_acc;
		end
	end

	// ==========================================================
	// Output levels for normal, PWM and one pulse modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl1 <= 1'b0;
			lvl2 <= 1'b0;
		end else if (ctrl.pwm) begin
			if (cmp1_hit) begin
				lvl1 <= ctrl.level2;
			end
			if (cmp2_hit) begin
				lvl1 <= ctrl.level1;
			end
		end else if (ctrl.opm) begin
			if (cap1_evt && !timer_freeze) begin
				lvl1 <= ctrl.level1;
			end
			if (cmp1_hit) begin
				lvl1 <= ctrl.level2;
			end
		end else begin
			if (cmp1_hit) begin
				lvl1 <= ctrl.level1;
			end
			if (cmp2_hit) begin
				lvl2 <= ctrl.level2;
			end
		end
	end

	// Pins go quiet while frozen to save power
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_output_one    <= 1'b0;
			compare_output_one_oe <= 1'b0;
			compare_output_two    <= 1'b0;
			compare_output_two_oe <= 1'b0;
		end else begin
			compare_output_one    <= lvl1 & ~timer_freeze;
			compare_output_one_oe <= ctrl.out1_en & ~timer_freeze;
			compare_output_two    <= lvl2 & ~timer_freeze & ~ctrl.pwm;
			compare_output_two_oe <= ctrl.out2_en & ~timer_freeze & ~ctrl.pwm;
		end
	end

	// ==========================================================
	// Interrupt requests follow flag and enable, one cycle late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_compare  <= 1'b0;
			irq_capture  <= 1'b0;
			irq_overflow <= 1'b0;
		end else begin
			irq_compare  <= ctrl.cmp_ie & (flags[sbt_pkg::FLG_CMP1] | flags[sbt_pkg::FLG_CMP2]);
			irq_capture  <= ctrl.cap_ie & (flags[sbt_pkg::FLG_CAP1] | flags[sbt_pkg::FLG_CAP2]);
			irq_overflow <= ctrl.ovf_ie & flags[sbt_pkg::FLG_OVF];
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ovf_pending;
		flags[sbt_pkg::FLG_OVF] && ctrl.ovf_ie;
	endsequence

	sequence s_alt_low_touch;
		flags[sbt_pkg::FLG_OVF] && sbt_hit(done, paddr, sbt_pkg::ADDR_ALT_LOW);
	endsequence

	property p_ovf_set;
		tick && count == 16'hFFFF && !restart && !cnt_low_wr |=> flags[2] && count == 16'h0000;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag missed wrap");

	property p_ovf_unarmed;
		flags[sbt_pkg::FLG_OVF] && !armed[sbt_pkg::FLG_OVF] |=> flags[sbt_pkg::FLG_OVF];
	endproperty
	a_ovf_unarmed: assert property (p_ovf_unarmed) else $error("overflow cleared unarmed");

	property p_alt_keep;
		s_alt_low_touch |=> flags[sbt_pkg::FLG_OVF];
	endproperty
	a_alt_keep: assert property (p_alt_keep) else $error("alternate access cleared overflow");

	property p_cmp1_set;
		cmp1_hit && !restart && !cnt_low_wr |=> flags[sbt_pkg::FLG_CMP1] && count == compare_one_value;
	endproperty
	a_cmp1_set: assert property (p_cmp1_set) else $error("compare one flag missed");

	property p_cmp1_clear;
		armed[3] && sbt_hit(done, paddr, sbt_pkg::ADDR_CMP1_LOW) && !cmp1_hit |=> !flags[3];
	endproperty
	a_cmp1_clear: assert property (p_cmp1_clear) else $error("compare one flag not cleared");

	property p_cmp2_set;
		cmp2_hit |=> flags[sbt_pkg::FLG_CMP2];
	endproperty
	a_cmp2_set: assert property (p_cmp2_set) else $error("compare two flag missed");

	property p_cap2;
		cap2_evt |=> flags[1] && capture_two_value == $past(count);
	endproperty
	a_cap2: assert property (p_cap2) else $error("capture two not taken");

	property p_freeze_hold;
		timer_freeze && !cnt_low_wr ##1 timer_freeze |-> $stable(count);
	endproperty
	a_freeze_hold: assert property (p_freeze_hold) else $error("counter moved while frozen");

	property p_freeze_pins;
		timer_freeze |=> !compare_output_one_oe && !compare_output_two_oe;
	endproperty
	a_freeze_pins: assert property (p_freeze_pins) else $error("compare pin driven while frozen");

	property p_ovf_irq;
		s_ovf_pending |=> irq_overflow;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("overflow interrupt not raised");

	property p_irq_drop;
		!flags[sbt_pkg::FLG_CMP1] && !flags[sbt_pkg::FLG_CMP2] |=> !irq_compare;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("compare interrupt without flag");

endmodule : sbt_timer
`default_nettype wire

// *** sbt_pkg.sv ***
// Constants and types shared by the sixteen-bit capture and compare timer
package sbt_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_STATUS    = 8'h04;
	localparam logic [7:0] ADDR_CAP1_HIGH = 8'h08;
	localparam logic [7:0] ADDR_CAP1_LOW  = 8'h0C;
	localparam logic [7:0] ADDR_CMP1_HIGH = 8'h10;
	localparam logic [7:0] ADDR_CMP1_LOW  = 8'h14;
	localparam logic [7:0] ADDR_CNT_HIGH  = 8'h18;
	localparam logic [7:0] ADDR_CNT_LOW   = 8'h1C;
	localparam logic [7:0] ADDR_ALT_HIGH  = 8'h20;
	localparam logic [7:0] ADDR_ALT_LOW   = 8'h24;
	localparam logic [7:0] ADDR_CAP2_HIGH = 8'h28;
	localparam logic [7:0] ADDR_CAP2_LOW  = 8'h2C;
	localparam logic [7:0] ADDR_CMP2_HIGH = 8'h30;
	localparam logic [7:0] ADDR_CMP2_LOW  = 8'h34;

	// ==========================================================
	// Status layout: flags occupy bits 7..3, freeze is bit 2
	localparam int BIT_FREEZE = 2;
	localparam int FLAG_LSB   = 3;
	localparam int FLG_CMP2   = 0;
	localparam int FLG_CAP2   = 1;
	localparam int FLG_OVF    = 2;
	localparam int FLG_CMP1   = 3;
	localparam int FLG_CAP1   = 4;

	// ==========================================================
	// Reset values and counter limits
	localparam logic [15:0] CNT_RESET = 16'hFFFC;
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;
	localparam logic [15:0] CMP_RESET = 16'h8000;
	localparam logic [15:0] CAP_RESET = 16'h0000;
	localparam int          DIV_WIDTH = 3;

	// ==========================================================
	// Prescaler source selection
	typedef enum logic [1:0] {
		SEL_DIV4 = 2'b00,
		SEL_DIV2 = 2'b01,
		SEL_DIV8 = 2'b10,
		SEL_EXT  = 2'b11
	} sbt_clksel_type;

	// Control register, bit 13 down to bit 0
	typedef struct packed {
		logic           opm;
		logic           pwm;
		logic           cap2_rise;
		logic           cap1_rise;
		logic           out2_en;
		logic           out1_en;
		logic           level2;
		logic           level1;
		logic           ovf_ie;
		logic           cap_ie;
		logic           cmp_ie;
		logic           ext_rise;
		sbt_clksel_type clk_sel;
	} sbt_ctrl_type;

	localparam sbt_ctrl_type CTRL_RESET = '0;

	// Edge detector shared by capture inputs and the external tick
	function automatic logic sbt_edge(input logic cur, input logic prev, input logic rise);
		return rise ? (cur & ~prev) : (~cur & prev);
	endfunction : sbt_edge

endpackage : sbt_pkg

// *** sbt_prescaler.sv ***
// Prescaler producing one-cycle counter ticks for the timer
`timescale 1ns/100ps
`default_nettype none
module sbt_prescaler (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    freeze,
	input  wire sbt_pkg::sbt_clksel_type clk_sel,
	input  wire logic                    ext_rise,
	input  wire logic                    ext_level,
	output logic                         tick
);

	logic [sbt_pkg::DIV_WIDTH-1:0] div;
	logic                          ext_prev;
	logic                          next_tick;

	// ==========================================================
	// Divider, held while frozen so the phase survives a freeze
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= '0;
		end else if (!freeze) begin
			div <= div + 3'h1;
		end
	end

	// External level history for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev <= 1'b1;
		end else begin
			ext_prev <= ext_level;
		end
	end

	// Tick select; an external source slower than a quarter of pclk never loses edges
	always_comb begin
		case (clk_sel)
			sbt_pkg::SEL_DIV2: next_tick = div[0];
			sbt_pkg::SEL_DIV4: next_tick = &div[1:0];
			sbt_pkg::SEL_DIV8: next_tick = &div;
			sbt_pkg::SEL_EXT:  next_tick = sbt_pkg::sbt_edge(ext_level, ext_prev, ext_rise);
			default:           next_tick = 1'b0;
		endcase
	end

	// Registered tick; nothing counts while frozen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick <= 1'b0;
		end else begin
			tick <= next_tick & ~freeze;
		end
	end

endmodule : sbt_prescaler
`default_nettype wire

// *** sbt_pin_model.sv ***
// Pin-side model of the capture inputs and the external tick source
`timescale 1ns/100ps
`default_nettype none
module sbt_pin_model (
	input  wire logic       pclk,
	input  wire logic       ext_run,
	input  wire logic [3:0] ext_half,
	input  wire logic       cap1_lvl,
	input  wire logic       cap2_lvl,
	output logic            capture_input_one,
	output logic            capture_input_two,
	output logic            external_tick_input
);
	logic [3:0] cnt;

	// ==========
	// Pins idle high like the synchronisers, so reset release shows no false edge
	initial begin
		cnt = 4'h0;
		capture_input_one = 1'b1;
		capture_input_two = 1'b1;
		external_tick_input = 1'b1;
	end

	// Capture pins take the commanded level just after an edge
	always @(posedge pclk) begin
		capture_input_one <= cap1_lvl;
		capture_input_two <= cap2_lvl;
	end

	// Tick stands still unless running; half period of four or more keeps it slow enough
	always @(posedge pclk) begin
		if (ext_run && cnt >= ext_half - 4'h1) begin
			cnt <= 4'h0;
			external_tick_input <= ~external_tick_input;
		end else if (ext_run) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : sbt_pin_model
`default_nettype wire

// *** sbt_timer_tb.sv ***
// Self-checking testbench of the capture and compare timer
`timescale 1ns/100ps
`default_nettype none
module sbt_timer_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cap1;
	logic        cap2;
	logic        ext;
	logic        out1;
	logic        out2;
	logic        oe1;
	logic        oe2;
	logic        irq_cmp;
	logic        irq_cap;
	logic        irq_ovf;
	logic        ext_run = 1'b0;
	logic        cap2_lvl = 1'b1;
	logic        err;
	logic [7:0]  r;
	logic [7:0]  a0;
	logic [15:0] v;
	logic        lvl;
	int          mismatches = 0;
	int          n_tests = 0;
	int          hi;

	// ==========
	// Clock at 40 MHz
	always #12.5 pclk = ~pclk;

	sbt_timer sbt_timer_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_input_one(cap1),
		.capture_input_two(cap2), .external_tick_input(ext),
		.compare_output_one(out1), .compare_output_one_oe(oe1),
		.compare_output_two(out2), .compare_output_two_oe(oe2),
		.irq_compare(irq_cmp), .irq_capture(irq_cap), .irq_overflow(irq_ovf)
	);

	sbt_pin_model sbt_pin_model_i (
		.pclk(pclk), .ext_run(ext_run), .ext_half(4'h4), .cap1_lvl(1'b1),
		.cap2_lvl(cap2_lvl), .capture_input_one(cap1),
		.capture_input_two(cap2), .external_tick_input(ext)
	);

	// ==========
	// Comparison, verdict and bus tasks
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	// Holds the request until pready is sampled high at a rising edge, bounded against a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [7:0] rd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			test_done();
		end
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Expected flag of a compare channel and tick period of a source
	function automatic logic [7:0] cmp_flag(input int ch);
		return (ch == 0) ? 8'h40 : 8'h08;
	endfunction : cmp_flag

	function automatic int period(input int i);
		return (i == 0) ? 2 : (i == 1) ? 4 : 8;
	endfunction : period

	// ==========
	// Main sequence
	initial begin
		logic [7:0] ra[6];
		logic [7:0] rv[6];
		logic [1:0] sel[4];
		ra = '{sbt_pkg::ADDR_ALT_HIGH, sbt_pkg::ADDR_CMP1_HIGH, sbt_pkg::ADDR_CMP1_LOW,
			sbt_pkg::ADDR_CMP2_HIGH, sbt_pkg::ADDR_CMP2_LOW, sbt_pkg::ADDR_CTRL};
		rv = '{8'hFF, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00};
		sel = '{2'b01, 2'b00, 2'b10, 2'b11};
		void'($urandom(32'h0994_cdc2));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// Status first: the counter wraps within a few dozen cycles of reset
		apb(1'b0, sbt_pkg::ADDR_STATUS, 16'h0000, r);
		chk("status_reset", r, 8'h00);
		apb(1'b0, sbt_pkg::ADDR_CNT_HIGH, 16'h0000, r);
		chk("cnt_high", r, 8'hFF);
		apb(1'b0, sbt_pkg::ADDR_CNT_LOW, 16'h0000, r);
		chk("cnt_low", r >= 8'hFC, 1'b1);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ra[i], 16'h0000, r);
			chk("reset_value", r, rv[i]);
		end
		$display("done: reset");
		// Same window of 8 periods must hold exactly 8 ticks for every source
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, sbt_pkg::ADDR_CTRL, {14'h0004, sel[i]}, r);
			ext_run <= (i == 3);
			repeat (20) @(posedge pclk);
			apb(1'b0, sbt_pkg::ADDR_CNT_LOW, 16'h0000, a0);
			repeat (8 * period(i) - 3) @(posedge pclk);
			apb(1'b0, sbt_pkg::ADDR_CNT_LOW, 16'h0000, r);
			chk("tick_rate", 8'(r - a0), 8'h08);
		end
		ext_run <= 1'b0;
		$display("done: prescaler");
		// Earlier wraps left overflow set: clear it while frozen before the real test
		apb(1'b1, sbt_pkg::ADDR_STATUS, 16'h0004, r);
		apb(1'b1, sbt_pkg::ADDR_CTRL, 16'h0021, r);
		apb(1'b0, sbt_pkg::ADDR_STATUS, 16'h0000, r);
		apb(1'b1, sbt_pkg::ADDR_CNT_LOW, 16'h0000, r);
		apb(1'b0, sbt_pkg::ADDR_STATUS, 16'h0000, r);
		chk("ovf_pre", r & 8'h20, 8'h00);
		apb(1'b1, sbt_pkg::ADDR_STATUS, 16'h0000, r);
		repeat (20) @(posedge pclk);
		apb(1'b0, sbt_pkg::ADDR_STATUS, 16'h0000, r);
		chk("ovf_set", r & 8'h20, 8'h20);
		chk("irq_ovf", irq_ovf, 1'b1);
		apb(1'b0, sbt_pkg::ADDR_ALT_LOW, 16'h0000, r);
		apb(1'b0, sbt_pkg::ADDR_STATUS, 16'h0000, r);
		chk("ovf_kept", r & 8'h20, 8'h20);
		apb(1'b0, sbt_pkg::ADDR_CNT_LOW, 16'h0000, r);
		repeat (2) @(posedge pclk);
		apb(1'b0, sbt_pkg::ADDR_STATUS, 16'h0000, r);
		chk("ovf_clear", r & 8'h20, 8'h00);
		chk("irq_ovf_low", irq_ovf, 1'b0);
		$display("done: overflow");
		// Random match value and output level on each compare channel
		for (int ch = 0; ch < 2; ch++) begin
			v = 16'(8 + $urandom % 40);
			lvl = 1'($urandom % 2);
			apb(1'b1, sbt_pkg::ADDR_STATUS, 16'h0004, r);
			apb(1'b1, ch ? sbt_pkg::ADDR_CMP2_HIGH : sbt_pkg::ADDR_CMP1_HIGH, v >> 8, r);
			apb(1'b1, ch ? sbt_pkg::ADDR_CMP2_LOW : sbt_pkg::ADDR_CMP1_LOW, v & 8'hFF, r);
			apb(1'b1, sbt_pkg::ADDR_CTRL, 16'h0309 | (lvl << (6 + ch)), r);
			apb(1'b1, sbt_pkg::ADDR_CNT_LOW, 16'h0000, r);
			apb(1'b1, sbt_pkg::ADDR_STATUS, 16'h0000, r);
			repeat (3) @(posedge pclk);
			chk("oe_on", {oe1, oe2}, 2'b11);
			repeat (2 * v + 40) @(posedge pclk);
			apb(1'b0, sbt_pkg::ADDR_STATUS, 16'h0000, r);
			chk("cmp_set", r & cmp_flag(ch), cmp_flag(ch));
			chk("irq_cmp", irq_cmp, 1'b1);
			if (ch == 0) chk("out1", out1, lvl);
			else chk("out2", out2, lvl);
			apb(1'b1, ch ? sbt_pkg::ADDR_CMP2_LOW : sbt_pkg::ADDR_CMP1_LOW, v & 8'hFF, r);
			repeat (2) @(posedge pclk);
			apb(1'b0, sbt_pkg::ADDR_STATUS, 16'h0000, r);
			chk("cmp_clear", r & cmp_flag(ch), 8'h00);
		end
		$display("done: compare");
		apb(1'b1, sbt_pkg::ADDR_STATUS, 16'h0004, r);
		repeat (3) @(posedge pclk);
		chk("oe_frozen", {oe1, oe2}, 2'b00);
		apb(1'b0, sbt_pkg::ADDR_CNT_LOW, 16'h0000, a0);
		repeat (10) @(posedge pclk);
		apb(1'b0, sbt_pkg::ADDR_CNT_LOW, 16'h0000, r);
		chk("cnt_held", r, a0);
		apb(1'b1, sbt_pkg::ADDR_CMP1_HIGH, 16'h005A, r);
		apb(1'b0, sbt_pkg::ADDR_CMP1_HIGH, 16'h0000, r);
		chk("frozen_rw", r, 8'h5A);
		$display("done: freeze");
		apb(1'b1, sbt_pkg::ADDR_CTRL, 16'h0811, r);
		apb(1'b1, sbt_pkg::ADDR_CNT_LOW, 16'h0000, r);
		// A falling edge first, which rising-edge capture must ignore
		cap2_lvl <= 1'b0;
		repeat (6) @(posedge pclk);
		cap2_lvl <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, sbt_pkg::ADDR_STATUS, 16'h0000, r);
		chk("cap2_set", r & 8'h10, 8'h10);
		chk("irq_cap", irq_cap, 1'b1);
		apb(1'b0, sbt_pkg::ADDR_CAP2_HIGH, 16'h0000, r);
		chk("cap2_high", r, 8'hFF);
		apb(1'b0, sbt_pkg::ADDR_CAP2_LOW, 16'h0000, r);
		chk("cap2_low", r, 8'hFC);
		repeat (2) @(posedge pclk);
		apb(1'b0, sbt_pkg::ADDR_STATUS, 16'h0000, r);
		chk("cap2_clear", r & 8'h10, 8'h00);
		$display("done: capture");
		// PWM at /2: period runs from restart to compare two, high until compare one
		apb(1'b1, sbt_pkg::ADDR_CMP1_HIGH, 16'h0000, r);
		apb(1'b1, sbt_pkg::ADDR_CMP1_LOW, 16'h0004, r);
		apb(1'b1, sbt_pkg::ADDR_CMP2_HIGH, 16'h0000, r);
		apb(1'b1, sbt_pkg::ADDR_CMP2_LOW, 16'h0010, r);
		apb(1'b1, sbt_pkg::ADDR_CTRL, 16'h1341, r);
		apb(1'b1, sbt_pkg::ADDR_STATUS, 16'h0000, r);
		repeat (60) @(posedge pclk);
		hi = 0;
		repeat (80) begin
			@(posedge pclk);
			hi += out1;
		end
		// Two whole periods: twice the high ticks, two pclk cycles each
		chk("pwm_high", 16'(hi), 16'(4 * 16'(16'h0004 - sbt_pkg::CNT_RESET)));
		chk("pwm_oe2", {oe2, out2}, 2'b00);
		$display("done: pwm");
		apb(1'b0, 8'h38, 16'h0000, r);
		chk("unmapped_err", err, 1'b1);
		chk("unmapped_data", r, 8'h00);
		$display("done: unmapped");
		test_done();
	end
endmodule : sbt_timer_tb
`default_nettype wire
